/* design/brake_seq_pkg.sv */
// shared constants for the brake interlock and fault sequencer
package brake_seq_pkg;
    // register bus shape
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;

    // register offsets
    localparam logic [ADDR_W-1:0] ADDR_OUT_SEL    = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_OFF_DELAY  = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_SPEED_LVL  = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_TIMEOUT    = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_STATUS     = 4'h4;

    // field widths
    localparam int SEL_W   = 2;
    localparam int DELAY_W = 6;
    localparam int SPEED_W = 14;
    localparam int TMO_W   = 7;
    localparam int CODE_W  = 3;
    localparam int PAIRS   = 3;

    // setting limits and reset values
    localparam logic [SEL_W-1:0]   SEL_RESET   = 2'h0;
    localparam logic [DELAY_W-1:0] DELAY_MAX   = 6'h32;   // 50
    localparam logic [DELAY_W-1:0] DELAY_RESET = 6'h00;
    localparam logic [SPEED_W-1:0] SPEED_MAX   = 14'h2710; // 10000 rpm
    localparam logic [SPEED_W-1:0] SPEED_RESET = 14'h0064; // 100 rpm
    localparam logic [TMO_W-1:0]   TMO_MAX     = 7'h64;   // 100
    localparam logic [TMO_W-1:0]   TMO_RESET   = 7'h32;   // 50

    // below this speed the motor counts as stopped
    localparam logic [SPEED_W-1:0] STANDSTILL_RPM = 14'h000a;

    // status word layout
    localparam int ST_STATE_LSB = 0;
    localparam int ST_FAULT_BIT = 2;
    localparam int ST_ENC_BIT   = 3;
    localparam int ST_CODE_LSB  = 4;
    localparam int ST_BRAKE_BIT = 7;
    localparam int ST_ENER_BIT  = 8;

    // timebase
    localparam int CLK_PERIOD_NS = 4;
    localparam int TICK_TIME_NS  = 10000000; // 10 ms
    localparam int TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        SEQ_OFF,
        SEQ_RUN,
        SEQ_STOP_DELAY,
        SEQ_MOVE_BRAKE
    } seq_state_t;
endpackage

/* design/tick_gen.sv */
// 10 ms tick generator with restart
`timescale 1ns/1ns
module tick_gen
    import brake_seq_pkg::*;
#(
    parameter int TickCycles = TICK_CYCLES
) (
    input  wire logic clk,        // device clock
    input  wire logic rst_b,      // async reset, active low
    input  wire logic restart,    // restart the period from zero
    output logic      tick        // one-cycle pulse every period
);
    logic [31:0] count_r;
    logic [31:0] count_nxt;
    logic        tick_nxt;

    // count up; restart gives a full period after each servo-off event
    always_comb begin
        count_nxt = count_r + 32'h0000_0001;
        tick_nxt  = 1'b0;
        if (restart) begin
            count_nxt = 32'h0000_0000;
        end else if (count_r >= 32'(TickCycles - 1)) begin
            count_nxt = 32'h0000_0000;
            tick_nxt  = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_r <= 32'h0000_0000;
            tick    <= 1'b0;
        end else begin
            count_r <= count_nxt;
            tick    <= tick_nxt;
        end
    end
endmodule

/* design/fault_latch.sv */
// latches one amplifier fault with its code until cleared
`timescale 1ns/1ns
module fault_latch
    import brake_seq_pkg::*;
(
    input  wire logic              clk,        // device clock
    input  wire logic              rst_b,      // async reset, active low
    input  wire logic              setFault,   // fault detected, pulse
    input  wire logic [CODE_W-1:0] setCode,    // type of that fault
    input  wire logic              setEncoder, // fault is encoder related
    input  wire logic              clearReq,   // clear request, pulse
    output logic                   faultActive_r, // fault latched
    output logic [CODE_W-1:0]      faultCode_r,   // latched fault type
    output logic                   encoderLatch_r // latched encoder fault
);
    logic              active_nxt;
    logic [CODE_W-1:0] code_nxt;
    logic              enc_nxt;

    // a new fault beats a clear arriving in the same cycle
    always_comb begin
        active_nxt = faultActive_r;
        code_nxt   = faultCode_r;
        enc_nxt    = encoderLatch_r;
        if (clearReq && !encoderLatch_r) begin
            active_nxt = 1'b0;
            code_nxt   = '0;
        end
        // encoder faults stay until power is cycled
        if (setFault) begin
            active_nxt = 1'b1;
            code_nxt   = setCode;
            enc_nxt    = encoderLatch_r | setEncoder;
        end
    end

    // power loss is the reset: everything clears
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            faultActive_r  <= 1'b0;
            faultCode_r    <= '0;
            encoderLatch_r <= 1'b0;
        end else begin
            faultActive_r  <= active_nxt;
            faultCode_r    <= code_nxt;
            encoderLatch_r <= enc_nxt;
        end
    end
endmodule

/* design/brake_interlock_alarm_sequencer.sv */
// brake interlock, servo-off timing and fault outputs of the amplifier
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns

module brake_interlock_alarm_sequencer
    import brake_seq_pkg::*;
#(
    parameter int TickCycles = TICK_CYCLES
) (
    input  wire logic               clk,            // 250 MHz device clock
    input  wire logic               rst_b,          // control power reset
    input  wire logic [ADDR_W-1:0]  regAddr,        // register address
    input  wire logic [DATA_W-1:0]  regWrData,      // register write data
    input  wire logic               regWr,          // write strobe
    input  wire logic               regRd,          // read strobe
    output logic      [DATA_W-1:0]  regRdData,      // read data, next cycle
    input  wire logic               servoEnableIn_b,// servo enable pin
    input  wire logic               fault_clear_in, // fault clear pin
    input  wire logic               panelClear,     // panel clear, pulse
    input  wire logic               faultDetect,    // fault event, pulse
    input  wire logic [CODE_W-1:0]  faultType,      // type of that fault
    input  wire logic               faultEncoder,   // fault is encoder one
    input  wire logic [SPEED_W-1:0] motorSpeed,     // actual speed, rpm
    input  wire logic [SPEED_W-1:0] motorMaxSpeed,  // motor maximum, rpm
    input  wire logic [PAIRS-1:0]   pairOtherSig,   // other signals per pair
    output logic                    motorEnergise,  // motor power stage on
    output logic                    brake_release_out_b, // brake, low=release
    output logic      [PAIRS-1:0]   outPair_b,      // output pairs, low=closed
    output logic                    fault_out_b,    // low=normal, high=fault
    output logic                    fault_code_bit0,// fault code bit 0
    output logic                    fault_code_bit1,// fault code bit 1
    output logic                    fault_code_bit2 // fault code bit 2
);
    // pin synchronisers
    logic enMeta_r;
    logic enSync_r;
    logic clrMeta_r;
    logic clrSync_r;
    logic clrPrev_r;

    // settings
    logic [SEL_W-1:0]   brake_terminal_select_r;
    logic [DELAY_W-1:0] brake_servo_off_delay_r;
    logic [SPEED_W-1:0] brake_speed_level_r;
    logic [TMO_W-1:0]   brake_output_timeout_r;
    logic [SEL_W-1:0]   sel_nxt;
    logic [DELAY_W-1:0] delay_nxt;
    logic [SPEED_W-1:0] level_nxt;
    logic [TMO_W-1:0]   tmo_nxt;
    logic [DATA_W-1:0]  rd_nxt;

    // sequencer
    seq_state_t         state_r;
    seq_state_t         state_nxt;
    logic [TMO_W-1:0]   ticks_r;
    logic [TMO_W-1:0]   ticks_nxt;
    logic               restart;
    logic               tick;
    logic               servoOn;
    logic               running;
    logic [SPEED_W-1:0] effLevel;
    logic               energise_nxt;
    logic               release_nxt;
    logic               brakeRelease_r;

    // fault path
    logic               clearReq;
    logic               faultActive;
    logic [CODE_W-1:0]  faultCode;
    logic               encoderLatch;
    logic               faultNow;

    // clamp a written value to its top setting
    function automatic logic [DATA_W-1:0] clampSet(
        input logic [DATA_W-1:0] value,
        input logic [DATA_W-1:0] limit
    );
        clampSet = (value > limit) ? limit : value;
    endfunction

    // two flops on each pin before any logic looks at it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            enMeta_r  <= 1'b1;
            enSync_r  <= 1'b1;
            clrMeta_r <= 1'b0;
            clrSync_r <= 1'b0;
            clrPrev_r <= 1'b0;
        end else begin
            enMeta_r  <= servoEnableIn_b;
            enSync_r  <= enMeta_r;
            clrMeta_r <= fault_clear_in;
            clrSync_r <= clrMeta_r;
            clrPrev_r <= clrSync_r;
        end
    end

    assign servoOn  = !enSync_r;
    // the rising edge of the pin, or the panel, asks for a clear
    assign clearReq = (clrSync_r && !clrPrev_r) ||
                      panelClear;

    fault_latch u_fault (
        .clk            (clk),
        .rst_b          (rst_b),
        .setFault       (faultDetect),
        .setCode        (faultType),
        .setEncoder     (faultEncoder),
        .clearReq       (clearReq),
        .faultActive_r  (faultActive),
        .faultCode_r    (faultCode),
        .encoderLatch_r (encoderLatch)
    );

    // a fresh event acts in its own cycle, not one later
    assign faultNow = faultActive || faultDetect;

    tick_gen #(
        .TickCycles (TickCycles)
    ) u_tick (
        .clk     (clk),
        .rst_b   (rst_b),
        .restart (restart),
        .tick    (tick)
    );

    // speed level never above what the motor can reach
    assign effLevel = (brake_speed_level_r > motorMaxSpeed) ?
                      motorMaxSpeed : brake_speed_level_r;
    assign running  = motorSpeed >= STANDSTILL_RPM;

    // servo-off sequencing
    always_comb begin
        state_nxt    = state_r;
        ticks_nxt    = ticks_r;
        restart      = 1'b0;
        energise_nxt = 1'b0;
        release_nxt  = 1'b0;
        if (tick && ticks_r != TMO_MAX) begin
            ticks_nxt = ticks_r + 7'h01;
        end
        case (state_r)
            SEQ_OFF: begin
                if (servoOn && !faultNow) begin
                    state_nxt = SEQ_RUN;
                end
            end
            SEQ_RUN: begin
                if (faultNow || !servoOn) begin
                    restart   = 1'b1;
                    ticks_nxt = '0;
                    if (running) begin
                        state_nxt = SEQ_MOVE_BRAKE;
                    end else if (faultNow ||
                                 brake_servo_off_delay_r == DELAY_RESET) begin
                        state_nxt = SEQ_OFF;
                    end else begin
                        state_nxt = SEQ_STOP_DELAY;
                    end
                end
            end
            SEQ_STOP_DELAY: begin
                // brake already applied, power held while it bites
                if (faultNow) begin
                    state_nxt = SEQ_OFF;
                end else if (ticks_nxt >=
                             TMO_W'(brake_servo_off_delay_r)) begin
                    state_nxt = SEQ_OFF;
                end
            end
            SEQ_MOVE_BRAKE: begin
                // power is off; brake held open until slow or timed out
                if (motorSpeed < effLevel) begin
                    state_nxt = SEQ_OFF;
                end else if (ticks_nxt >= brake_output_timeout_r) begin
                    state_nxt = SEQ_OFF;
                end
            end
            default: begin
                state_nxt = SEQ_OFF;
            end
        endcase
        // outputs follow the next state so both change on one edge
        energise_nxt = (state_nxt == SEQ_RUN) ||
                       (state_nxt == SEQ_STOP_DELAY);
        release_nxt  = (state_nxt == SEQ_RUN) ||
                       (state_nxt == SEQ_MOVE_BRAKE);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r        <= SEQ_OFF;
            ticks_r        <= '0;
            motorEnergise  <= 1'b0;
            brakeRelease_r <= 1'b0;
        end else begin
            state_r        <= state_nxt;
            ticks_r        <= ticks_nxt;
            motorEnergise  <= energise_nxt;
            brakeRelease_r <= release_nxt;
        end
    end

    // register writes, clamped to the documented ranges
    always_comb begin
        sel_nxt   = brake_terminal_select_r;
        delay_nxt = brake_servo_off_delay_r;
        level_nxt = brake_speed_level_r;
        tmo_nxt   = brake_output_timeout_r;
        rd_nxt    = '0;
        if (regWr) begin
            case (regAddr)
                ADDR_OUT_SEL:   sel_nxt   = regWrData[SEL_W-1:0];
                ADDR_OFF_DELAY: delay_nxt = DELAY_W'(clampSet(regWrData,
                                            DATA_W'(DELAY_MAX)));
                ADDR_SPEED_LVL: level_nxt = SPEED_W'(clampSet(regWrData,
                                            DATA_W'(SPEED_MAX)));
                ADDR_TIMEOUT:   tmo_nxt   = TMO_W'(clampSet(regWrData,
                                            DATA_W'(TMO_MAX)));
                default:        sel_nxt   = brake_terminal_select_r;
            endcase
        end
        if (regRd) begin
            case (regAddr)
                ADDR_OUT_SEL:   rd_nxt = DATA_W'(brake_terminal_select_r);
                ADDR_OFF_DELAY: rd_nxt = DATA_W'(brake_servo_off_delay_r);
                ADDR_SPEED_LVL: rd_nxt = DATA_W'(brake_speed_level_r);
                ADDR_TIMEOUT:   rd_nxt = DATA_W'(brake_output_timeout_r);
                ADDR_STATUS: begin
                    rd_nxt[ST_STATE_LSB +: 2]      = state_r;
                    rd_nxt[ST_FAULT_BIT]           = faultActive;
                    rd_nxt[ST_ENC_BIT]             = encoderLatch;
                    rd_nxt[ST_CODE_LSB +: CODE_W]  = faultCode;
                    rd_nxt[ST_BRAKE_BIT]           = brakeRelease_r;
                    rd_nxt[ST_ENER_BIT]            = motorEnergise;
                end
                default:        rd_nxt = '0; // unmapped reads zero
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            brake_terminal_select_r <= SEL_RESET;
            brake_servo_off_delay_r <= DELAY_RESET;
            brake_speed_level_r     <= SPEED_RESET;
            brake_output_timeout_r  <= TMO_RESET;
            regRdData               <= '0;
        end else begin
            brake_terminal_select_r <= sel_nxt;
            brake_servo_off_delay_r <= delay_nxt;
            brake_speed_level_r     <= level_nxt;
            brake_output_timeout_r  <= tmo_nxt;
            regRdData               <= rd_nxt;
        end
    end

    // brake output: closed (low) means release
    assign brake_release_out_b = !brakeRelease_r;

    // output pairs, active low; a pair is closed if any mapped signal is on
    genvar p;
    generate
        for (p = 0; p < PAIRS; p++) begin : g_pair
            assign outPair_b[p] = !(pairOtherSig[p] ||
                (brakeRelease_r &&
                 brake_terminal_select_r == SEL_W'(p + 1)));
        end
    endgenerate

    // fault outputs; the host opens the amplifier supply on fault_out_b
    assign fault_out_b     = faultActive;
    assign fault_code_bit0 = faultCode[0];
    assign fault_code_bit1 = faultCode[1];
    assign fault_code_bit2 = faultCode[2];
endmodule

/* verification/brake_seq_chk.sv */
// port checker for the brake interlock and fault sequencer
`timescale 1ns/1ns
module brake_seq_chk
    import brake_seq_pkg::*;
#(
    parameter int TickCycles = TICK_CYCLES
) (
    input wire logic               clk,                 // device clock
    input wire logic               rst_b,               // reset, active low
    input wire logic               servoEnableIn_b,     // servo enable pin
    input wire logic               faultDetect,         // fault event
    input wire logic [CODE_W-1:0]  faultType,           // fault type
    input wire logic [PAIRS-1:0]   pairOtherSig,        // other pair signals
    input wire logic               motorEnergise,       // motor powered
    input wire logic               brake_release_out_b, // brake output
    input wire logic [PAIRS-1:0]   outPair_b,           // output pairs
    input wire logic               fault_out_b,         // fault output
    input wire logic               fault_code_bit0,     // code bit 0
    input wire logic               fault_code_bit1,     // code bit 1
    input wire logic               fault_code_bit2      // code bit 2
);
    // worst case: timeout 100 ticks plus two spare periods and 8 cycles
    localparam int MvMax = TickCycles * 102 + 8;
    logic [15:0] mvCnt_r;
    logic [15:0] mvCnt_nxt;

    // cycles spent with motor off but brake still released
    always_comb begin
        mvCnt_nxt = 16'h0000;
        if (!motorEnergise && !brake_release_out_b) begin
            mvCnt_nxt = mvCnt_r + 16'h0001;
        end
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mvCnt_r <= 16'h0000;
        end else begin
            mvCnt_r <= mvCnt_nxt;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    fault_set_a: assert property (faultDetect |=> fault_out_b)
        else $error("fault output not raised after fault event");
    fault_origin_a: assert property ($rose(fault_out_b) |->
        $past(faultDetect))
        else $error("fault output raised without a fault event");
    code_show_a: assert property (faultDetect && !fault_out_b |=>
        {fault_code_bit2, fault_code_bit1, fault_code_bit0}
            == $past(faultType))
        else $error("fault code does not match fault type");
    fault_stop_a: assert property (faultDetect |->
        ##[1:2] !motorEnergise)
        else $error("motor still energised after fault");
    servo_on_a: assert property ($rose(motorEnergise) |->
        !brake_release_out_b && $past(servoEnableIn_b, 2) == 1'b0)
        else $error("motor energised without servo enable or release");
    pair_or_a: assert property ((pairOtherSig & outPair_b) == 3'h0)
        else $error("pair open while another signal drives it");
    pair_route_a: assert property (
        (~outPair_b & ~pairOtherSig) != 3'h0 |-> !brake_release_out_b)
        else $error("pair closed with brake applied");
    brake_wait_a: assert property (mvCnt_r <= MvMax)
        else $error("brake kept released past the timeout");
    reset_clear_a: assert property (disable iff (1'b0)
        !rst_b |-> !fault_out_b && brake_release_out_b && !motorEnergise)
        else $error("outputs not cleared during reset");
endmodule

bind brake_interlock_alarm_sequencer brake_seq_chk #(
    .TickCycles(TickCycles)
) i_chk (.*);

/* verification/host_motor_model.sv */
// far-side model: host controller and motor load
`timescale 1ns/1ns
module host_motor_model
    import brake_seq_pkg::*;
(
    input  wire logic               clk,             // device clock
    input  wire logic               rst_b,           // reset, active low
    input  wire logic               hostOn,          // host wants servo on
    input  wire logic               coast,           // load holds speed
    input  wire logic [SPEED_W-1:0] targetSpeed,     // speed while powered
    input  wire logic               motorEnergise,   // amplifier output on
    input  wire logic               fault_out_b,     // fault output
    output logic                    servoEnableIn_b, // servo enable pin
    output logic      [SPEED_W-1:0] motorSpeed       // actual speed
);
    // host drops servo enable as soon as the fault output opens
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            servoEnableIn_b <= 1'b1;
        end else begin
            servoEnableIn_b <= !(hostOn && !fault_out_b);
        end
    end
    // unpowered motor slows by a fixed step unless the load drives it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            motorSpeed <= 14'h0000;
        end else if (motorEnergise) begin
            motorSpeed <= targetSpeed;
        end else if (!coast) begin
            motorSpeed <= (motorSpeed > 14'h0008) ?
                motorSpeed - 14'h0008 : 14'h0000;
        end
    end
endmodule

/* verification/brake_interlock_alarm_sequencer_test.sv */
// self-checking bench for the brake interlock and fault sequencer
`timescale 1ns/1ns
module brake_interlock_alarm_sequencer_test;
    import brake_seq_pkg::*;
    localparam int Tc = 4;
    logic clk = 1'b0, rst_b = 1'b1, regWr = 1'b0, regRd = 1'b0;
    logic [ADDR_W-1:0] regAddr = '0;
    logic [DATA_W-1:0] regWrData = '0, regRdData;
    logic servoEnableIn_b, fault_clear_in = 1'b0, panelClear = 1'b0;
    logic faultDetect = 1'b0, faultEncoder = 1'b0, hostOn = 1'b0;
    logic coast = 1'b0;
    logic [CODE_W-1:0] faultType = '0;
    logic [SPEED_W-1:0] motorSpeed, targetSpeed = '0;
    logic [SPEED_W-1:0] motorMaxSpeed = 14'h2710;
    logic [PAIRS-1:0] pairOtherSig = '0, outPair_b;
    logic motorEnergise, brake_release_out_b, fault_out_b;
    logic fault_code_bit0, fault_code_bit1, fault_code_bit2;
    int fail_count = 0, total_checks = 0;

    brake_interlock_alarm_sequencer #(.TickCycles(Tc)) i_dut (.*);
    host_motor_model i_far (.*);

    always #2 clk = ~clk;

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic regW(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic regR(input logic [3:0] a, input logic [15:0] e,
                        input string what);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        chk(what, e, regRdData);
    endtask
    // which 0 watches the energise output, 1 the brake output
    task automatic waitLvl(input int which, input logic lvl, output int n);
        logic v;
        for (n = 0; n < 3000; n++) begin
            @(posedge clk);
            #1;
            v = (which == 0) ? motorEnergise : brake_release_out_b;
            if (v === lvl) break;
        end
        if (n == 3000) begin
            fail_count++;
            $display("[ERR] wait %0d expected %h seen %h", which, lvl, v);
            conclude();
        end
    endtask
    task automatic fault(input logic [2:0] c, input logic enc);
        @(posedge clk);
        faultDetect <= 1'b1;
        faultType <= c;
        faultEncoder <= enc;
        @(posedge clk);
        faultDetect <= 1'b0;
        #1;
    endtask
    task automatic clearPulse();
        @(posedge clk);
        panelClear <= 1'b1;
        @(posedge clk);
        panelClear <= 1'b0;
        #1;
    endtask

    task automatic t_regs();
        regR(ADDR_OUT_SEL, 16'h0000, "select reset");
        regR(ADDR_OFF_DELAY, 16'h0000, "delay reset");
        regR(ADDR_SPEED_LVL, 16'h0064, "level reset");
        regR(ADDR_TIMEOUT, 16'h0032, "timeout reset");
        regW(ADDR_OFF_DELAY, 16'h003f);
        regW(ADDR_SPEED_LVL, 16'h3000);
        regW(ADDR_TIMEOUT, 16'h007f);
        regW(ADDR_STATUS, 16'hffff);
        regR(ADDR_OFF_DELAY, 16'h0032, "delay clamp");
        regR(ADDR_SPEED_LVL, 16'h2710, "level clamp");
        regR(ADDR_TIMEOUT, 16'h0064, "timeout clamp");
        regR(ADDR_STATUS, 16'h0000, "status idle");
        regR(4'h9, 16'h0000, "unmapped");
        $display("test regs done");
    endtask
    // stop at standstill with a given servo-off delay in ticks
    task automatic t_stop(input logic [15:0] d);
        int n;
        regW(ADDR_OFF_DELAY, d);
        targetSpeed <= 14'h0000;
        hostOn <= 1'b1;
        waitLvl(0, 1'b1, n);
        chk("brake on run", 16'h0000, brake_release_out_b);
        @(posedge clk);
        hostOn <= 1'b0;
        waitLvl(1, 1'b1, n);
        if (d == 16'h0000) begin
            chk("energise at apply", 16'h0000, motorEnergise);
        end else begin
            chk("energise held", 16'h0001, motorEnergise);
            waitLvl(0, 1'b0, n);
            chk("delay span", 16'h0001,
                n >= d * Tc - 1 && n <= (d + 1) * Tc + 2);
        end
        $display("test stop done");
    endtask
    // servo off or a fault while running; brake ends on speed or on timeout
    task automatic t_move(input logic [15:0] lvl, input logic [15:0] tmo,
                          input logic [13:0] mx, input logic hold,
                          input logic byFault);
        int n;
        logic [15:0] lim;
        lim = (lvl > mx) ? mx : lvl;
        regW(ADDR_SPEED_LVL, lvl);
        regW(ADDR_TIMEOUT, tmo);
        motorMaxSpeed <= mx;
        targetSpeed <= 14'h0190;
        coast <= hold;
        hostOn <= 1'b1;
        waitLvl(0, 1'b1, n);
        if (byFault) begin
            fault(3'h6, 1'b0);
            hostOn <= 1'b0;
        end else begin
            @(posedge clk);
            hostOn <= 1'b0;
        end
        waitLvl(0, 1'b0, n);
        chk("prompt off", 16'h0001, n <= 3);
        chk("still released", 16'h0000, brake_release_out_b);
        waitLvl(1, 1'b1, n);
        if (hold) begin
            chk("timeout span", 16'h0001,
                n >= tmo * Tc - 1 && n <= (tmo + 1) * Tc + 2);
        end else begin
            chk("speed level", 16'h0001,
                motorSpeed < lim && motorSpeed + 16 >= lim);
        end
        coast <= 1'b0;
        if (byFault) clearPulse();
        $display("test move done");
    endtask
    task automatic t_route();
        int n;
        targetSpeed <= 14'h0000;
        hostOn <= 1'b1;
        waitLvl(0, 1'b1, n);
        for (int s = 0; s < 4; s++) begin
            regW(ADDR_OUT_SEL, 16'(s));
            #1;
            chk("pair route", (s == 0) ? 16'h0007 :
                {13'h0000, ~(3'h1 << (s - 1))}, outPair_b);
        end
        pairOtherSig <= 3'h5;
        hostOn <= 1'b0;
        waitLvl(1, 1'b1, n);
        chk("pair or", 16'h0002, outPair_b);
        pairOtherSig <= 3'h0;
        $display("test route done");
    endtask
    task automatic t_faults();
        int n;
        for (int c = 0; c < 8; c++) begin
            fault(3'(c), 1'b0);
            chk("fault out", 16'h0001, fault_out_b);
            chk("fault code", 16'(c), {fault_code_bit2,
                fault_code_bit1, fault_code_bit0});
            clearPulse();
            chk("panel clear", 16'h0000, fault_out_b);
        end
        hostOn <= 1'b1;
        waitLvl(0, 1'b1, n);
        fault(3'h5, 1'b0);
        @(posedge clk);
        hostOn <= 1'b0;
        #1;
        chk("fault stop", 16'h0000, motorEnergise);
        // cause gone and servo off before the clear pin rises
        fault_clear_in <= 1'b1;
        repeat (4) @(posedge clk);
        fault_clear_in <= 1'b0;
        #1;
        chk("pin clear", 16'h0000, fault_out_b);
        fault(3'h7, 1'b1);
        clearPulse();
        chk("encoder kept", 16'h0001, fault_out_b);
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        chk("reset clear", 16'h0000, fault_out_b);
        $display("test faults done");
    endtask

    initial begin
        // a real falling edge, so reset acts before the first clock
        #1 rst_b = 1'b0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        t_regs();
        t_stop(16'h0000);
        t_stop(16'h0003);
        t_move(16'h0064, 16'h0064, 14'h2710, 1'b0, 1'b0);
        t_move(16'h2710, 16'h0064, 14'h00c8, 1'b0, 1'b0);
        t_move(16'h0064, 16'h0002, 14'h2710, 1'b1, 1'b1);
        t_route();
        t_faults();
        conclude();
    end
endmodule
